// file: dbgcs_pkg.sv
// Behaviour
// - Top nibble reports breakpoint state, read-only
// - State clears on trigger write, qualified read
// - Double fault entry sets bit 27
// - Hardware trigger sets bit 26; resume clears
// - Halt entry sets bit 25; resume clears
// - Break input entry sets bit 24
// - Fixed revision level in bits 23-20
// - Edge mode: falling break raises interrupt
// - No nesting of debug interrupts
// - Trace disable quiets trace outputs
// - Write inhibit blocks processor writes
// - Map bit selects emulator space encoding
// - Trace exception enters emulator mode
// - Force bit starts emulator mode
// - Capture field selects read/write data
// - Operand shown one nibble per cycle
// - Processor writes only; port reads, writes
// - Register lives at debug index 0x00
// - Bit 10 permits halt in user mode
// - Bits 9-8 choose branch target bytes
package dbgcs_pkg;
    localparam logic [4:0]  REG_INDEX      = 5'h00;
    localparam int          BREAKPOINT_STATE_LSB      = 28;
    localparam int          FOF_BIT        = 27;
    localparam int          TRG_BIT        = 26;
    localparam int          HALT_BIT       = 25;
    localparam int          BRK_BIT        = 24;
    localparam int          REV_LSB        = 20;
    localparam int          EDGE_BIT       = 18;
    localparam int          TOD_BIT        = 17;
    localparam int          INH_BIT        = 16;
    localparam int          MAP_BIT        = 15;
    localparam int          TRC_BIT        = 14;
    localparam int          EMU_BIT        = 13;
    localparam int          DDC_LSB        = 11;
    localparam int          UHP_BIT        = 10;
    localparam int          BTB_LSB        = 8;
    localparam logic [31:0] CTRL_MASK      = 32'h0007_FF00;
    localparam logic [31:0] RESET_VALUE    = 32'h0000_0000;
    localparam logic [3:0]  BS_IDLE        = 4'h0;
    localparam logic [3:0]  BS_WAIT1       = 4'h1;
    localparam logic [3:0]  BS_TRIG1       = 4'h2;
    localparam logic [3:0]  BS_WAIT2       = 4'h5;
    localparam logic [3:0]  BS_TRIG2       = 4'h6;
    localparam logic [1:0]  TT_EMULATOR    = 2'h2;
    localparam logic [2:0]  TM_EMU_DATA    = 3'h5;
    localparam logic [2:0]  TM_EMU_CODE    = 3'h6;
    localparam logic [2:0]  TM_SUPV_DATA   = 3'h5;
    localparam logic [2:0]  TM_SUPV_CODE   = 3'h6;
    localparam logic [1:0]  TT_NORMAL      = 2'h0;
    localparam logic [1:0]  DDC_NONE       = 2'h0;
    localparam logic [1:0]  DDC_WRITE      = 2'h1;
    localparam logic [1:0]  DDC_READ       = 2'h2;
    localparam logic [1:0]  SIZE_BYTE      = 2'h1;
    localparam logic [1:0]  SIZE_WORD      = 2'h2;
    localparam logic [1:0]  SIZE_LONG      = 2'h0;
    localparam logic [3:0]  NIB_BYTE       = 4'h2;
    localparam logic [3:0]  NIB_WORD       = 4'h4;
    localparam logic [3:0]  NIB_LONG       = 4'h8;
    localparam logic [3:0]  PST_QUIET      = 4'h0;
    localparam logic [3:0]  DATA_QUIET     = 4'h0;
endpackage

// file: dbgcs_nibble_ser.sv
`timescale 1ns/1ps
// ****************************************
// Operand nibble serialiser
// ****************************************
module dbgcs_nibble_ser #(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    // Load side
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] data_i,
    input  wire logic [3:0]       count_i,
    // Nibble side
    output logic                  busy_o,
    output logic [3:0]            nibble_o
);
    initial begin
        if (WIDTH != 32) $error("dbgcs_nibble_ser: WIDTH must be 32");
    end

    logic [WIDTH-1:0] shreg;
    logic [3:0]       left;

    assign busy_o   = (left != 4'h0);
    assign nibble_o = shreg[3:0];

    // Low nibble first, one per cycle
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            shreg <= '0;
            left  <= 4'h0;
        end else if (load_i && !busy_o) begin
            shreg <= data_i;
            left  <= count_i;
        end else if (busy_o) begin
            shreg <= {4'h0, shreg[WIDTH-1:4]};
            left  <= left - 4'h1;
        end
    end
endmodule // dbgcs_nibble_ser

// file: dbgcs_core.sv
`timescale 1ns/1ps
// ****************************************
// Debug configuration and status register
// ****************************************
module dbgcs_core #(
    parameter logic [3:0] REVISION = 4'h3 // Arbitrary value
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // Processor debug-write instruction
    input  wire logic        cpu_wr_i,
    input  wire logic [4:0]  cpu_idx_i,
    input  wire logic [31:0] cpu_wdata_i,
    input  wire logic        cpu_supv_i,
    // Debug port commands
    input  wire logic        port_wr_i,
    input  wire logic        port_rd_i,
    input  wire logic [4:0]  port_idx_i,
    input  wire logic [31:0] port_wdata_i,
    output logic [31:0]      port_rdata_o,
    output logic             port_rvalid_o,
    // Breakpoint logic status
    input  wire logic        tdr_write_i,
    input  wire logic [3:0]  bp_state_i,
    input  wire logic        bp_state_upd_i,
    input  wire logic        level2_enabled_i,
    // Entry causes and resume
    input  wire logic        double_fault_i,
    input  wire logic        hw_trigger_i,
    input  wire logic        halt_exec_i,
    input  wire logic        break_request_input_i,
    input  wire logic        resume_i,
    // Interrupt handling
    input  wire logic        sample_point_i,
    input  wire logic        dbg_int_done_i,
    output logic             dbg_int_o,
    output logic             bdm_enter_o,
    // Emulator mode
    input  wire logic        trace_exc_i,
    input  wire logic        emu_active_i,
    input  wire logic        emu_code_i,
    output logic             emu_enter_o,
    output logic [1:0]       transfer_type_o,
    output logic [2:0]       transfer_modifier_o,
    // Configuration fields
    output logic             user_halt_permit_o,
    output logic [1:0]       branch_target_bytes_o,
    // Operand capture and trace
    input  wire logic        op_valid_i,
    input  wire logic        op_write_i,
    input  wire logic [1:0]  op_size_i,
    input  wire logic [31:0] op_data_i,
    input  wire logic [3:0]  pst_i,
    output logic             trace_clock_o,
    output logic [3:0]       processor_status_out_o,
    output logic [3:0]       debug_data_out_o
);
    // ****************************************
    // Register state
    // ****************************************
    logic [3:0]  breakpoint_state;
    logic        fault_on_fault_flag;
    logic        hw_trigger_entry_flag;
    logic        halt_entry_flag;
    logic        break_req_flag;
    logic [31:0] ctrl;
    logic        brk_q;
    logic        int_pend;
    logic        in_service;

    function automatic logic hits(input logic [4:0] idx);
        hits = (idx == dbgcs_pkg::REG_INDEX);
    endfunction

    // ****************************************
    // Access decode
    // ****************************************
    wire port_wr_hit = port_wr_i && hits(port_idx_i);
    wire port_rd_hit = port_rd_i && hits(port_idx_i);
    wire inhibit     = ctrl[dbgcs_pkg::INH_BIT];
    wire cpu_wr_hit  = cpu_wr_i && cpu_supv_i && hits(cpu_idx_i) && !inhibit;
    wire [31:0] cpu_keep = dbgcs_pkg::CTRL_MASK & ~(32'h1 << dbgcs_pkg::INH_BIT);
    wire [31:0] next_ctrl_port = port_wdata_i & dbgcs_pkg::CTRL_MASK;
    wire [31:0] next_ctrl_cpu  = (cpu_wdata_i & cpu_keep) | (ctrl & ~cpu_keep);
    wire edge_mode   = ctrl[dbgcs_pkg::EDGE_BIT];
    wire trace_off   = ctrl[dbgcs_pkg::TOD_BIT];
    wire [1:0] ddc   = ctrl[dbgcs_pkg::DDC_LSB +: 2];

    wire bs_clear_rd = port_rd_hit && ((breakpoint_state == dbgcs_pkg::BS_TRIG2) ||
                       ((breakpoint_state == dbgcs_pkg::BS_TRIG1) && !level2_enabled_i));
    wire brk_fall    = brk_q && !break_request_input_i;
    wire brk_force   = !edge_mode && break_request_input_i;
    wire brk_int     = edge_mode && brk_fall;

    wire [31:0] status_word = {breakpoint_state, fault_on_fault_flag, hw_trigger_entry_flag,
                               halt_entry_flag, break_req_flag, REVISION, 20'h0};
    wire [31:0] read_word   = status_word | ctrl;

    // ****************************************
    // Control bits
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ctrl <= dbgcs_pkg::RESET_VALUE;
        end else if (port_wr_hit) begin
            ctrl <= next_ctrl_port;
        end else if (cpu_wr_hit) begin
            ctrl <= next_ctrl_cpu;
        end
    end

    // ****************************************
    // Breakpoint state
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            breakpoint_state <= dbgcs_pkg::BS_IDLE;
        end else if (bp_state_upd_i) begin
            breakpoint_state <= bp_state_i;
        end else if (tdr_write_i || bs_clear_rd) begin
            breakpoint_state <= dbgcs_pkg::BS_IDLE;
        end
    end

    // ****************************************
    // Entry cause flags
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            fault_on_fault_flag   <= 1'b0;
            hw_trigger_entry_flag <= 1'b0;
            halt_entry_flag       <= 1'b0;
            break_req_flag        <= 1'b0;
        end else begin
            fault_on_fault_flag   <= double_fault_i || (fault_on_fault_flag && !resume_i);
            hw_trigger_entry_flag <= hw_trigger_i || (hw_trigger_entry_flag && !resume_i);
            halt_entry_flag       <= halt_exec_i || (halt_entry_flag && !resume_i);
            break_req_flag        <= brk_force || (break_req_flag && !resume_i);
        end
    end

    // ****************************************
    // Debug interrupt
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            brk_q      <= 1'b0;
            int_pend   <= 1'b0;
            in_service <= 1'b0;
            dbg_int_o  <= 1'b0;
        end else begin
            brk_q      <= break_request_input_i;
            int_pend   <= brk_int || (int_pend && !(sample_point_i && !in_service));
            dbg_int_o  <= int_pend && sample_point_i && !in_service;
            if (int_pend && sample_point_i && !in_service) begin
                in_service <= 1'b1;
            end else if (dbg_int_done_i) begin
                in_service <= 1'b0;
            end
        end
    end

    // ****************************************
    // Mode and mapping outputs
    // ****************************************
    wire [1:0] next_tt = ctrl[dbgcs_pkg::MAP_BIT] ? dbgcs_pkg::TT_EMULATOR
                                                  : dbgcs_pkg::TT_NORMAL;
    wire [2:0] next_tm = ctrl[dbgcs_pkg::MAP_BIT]
                       ? (emu_code_i ? dbgcs_pkg::TM_EMU_CODE : dbgcs_pkg::TM_EMU_DATA)
                       : (emu_code_i ? dbgcs_pkg::TM_SUPV_CODE : dbgcs_pkg::TM_SUPV_DATA);
    wire next_emu = ctrl[dbgcs_pkg::EMU_BIT] ||
                    (ctrl[dbgcs_pkg::TRC_BIT] && trace_exc_i);

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            bdm_enter_o           <= 1'b0;
            emu_enter_o           <= 1'b0;
            transfer_type_o       <= dbgcs_pkg::TT_NORMAL;
            transfer_modifier_o   <= dbgcs_pkg::TM_SUPV_DATA;
            user_halt_permit_o    <= 1'b0;
            branch_target_bytes_o <= 2'h0;
            port_rdata_o          <= 32'h0000_0000;
            port_rvalid_o         <= 1'b0;
        end else begin
            bdm_enter_o           <= double_fault_i || hw_trigger_i || halt_exec_i || brk_force;
            emu_enter_o           <= next_emu;
            transfer_type_o       <= emu_active_i ? next_tt : dbgcs_pkg::TT_NORMAL;
            transfer_modifier_o   <= next_tm;
            user_halt_permit_o    <= ctrl[dbgcs_pkg::UHP_BIT];
            branch_target_bytes_o <= ctrl[dbgcs_pkg::BTB_LSB +: 2];
            port_rdata_o          <= port_rd_hit ? read_word : 32'h0000_0000;
            port_rvalid_o         <= port_rd_hit;
        end
    end

    // ****************************************
    // Operand capture
    // ****************************************
    wire cap_sel = (ddc == 2'h3) || (ddc == dbgcs_pkg::DDC_WRITE && op_write_i) ||
                   (ddc == dbgcs_pkg::DDC_READ && !op_write_i);
    wire capture = op_valid_i && (ddc != dbgcs_pkg::DDC_NONE) && cap_sel && !trace_off;
    wire [3:0] nib_count = (op_size_i == dbgcs_pkg::SIZE_BYTE) ? dbgcs_pkg::NIB_BYTE :
                           (op_size_i == dbgcs_pkg::SIZE_WORD) ? dbgcs_pkg::NIB_WORD :
                           dbgcs_pkg::NIB_LONG;
    logic       ser_busy;
    logic [3:0] ser_nib;

    dbgcs_nibble_ser #(.WIDTH(32)) u_ser (
        .clk_i    (clk_i),
        .nrst_i   (nrst_i),
        .load_i   (capture),
        .data_i   (op_data_i),
        .count_i  (nib_count),
        .busy_o   (ser_busy),
        .nibble_o (ser_nib)
    );

    // ****************************************
    // Trace outputs
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!nrst_i || trace_off) begin
            trace_clock_o          <= 1'b0;
            processor_status_out_o <= dbgcs_pkg::PST_QUIET;
            debug_data_out_o       <= dbgcs_pkg::DATA_QUIET;
        end else begin
            trace_clock_o          <= ~trace_clock_o;
            processor_status_out_o <= pst_i;
            debug_data_out_o       <= ser_busy ? ser_nib : dbgcs_pkg::DATA_QUIET;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_inhibit_blocks: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (inhibit && cpu_wr_i && !port_wr_hit) |=> $stable(ctrl))
        else $error("cpu write changed register while inhibited");
    a_trg_clears: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (resume_i && !hw_trigger_i) |=> !hw_trigger_entry_flag)
        else $error("trigger flag survived resume");
    a_halt_sets: assert property (@(posedge clk_i) disable iff (!nrst_i)
        halt_exec_i |=> halt_entry_flag)
        else $error("halt flag not set");
    a_fof_sets: assert property (@(posedge clk_i) disable iff (!nrst_i)
        double_fault_i |=> fault_on_fault_flag)
        else $error("fault flag not set");
    a_tdr_clears: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (tdr_write_i && !bp_state_upd_i) |=> breakpoint_state == dbgcs_pkg::BS_IDLE)
        else $error("state not cleared on trigger write");
    a_rev_fixed: assert property (@(posedge clk_i) disable iff (!nrst_i)
        port_rvalid_o |-> port_rdata_o[dbgcs_pkg::REV_LSB +: 4] == REVISION)
        else $error("revision field wrong");
    a_trace_quiet: assert property (@(posedge clk_i) disable iff (!nrst_i)
        trace_off |=> (!trace_clock_o && debug_data_out_o == 4'h0))
        else $error("trace outputs active while disabled");
    a_edge_int: assert property (@(posedge clk_i) disable iff (!nrst_i)
        brk_int |=> int_pend)
        else $error("falling break edge not pending");
    a_no_nest: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (in_service && !dbg_int_done_i) |=> !dbg_int_o)
        else $error("nested debug interrupt");
    a_map_space: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (emu_active_i && ctrl[dbgcs_pkg::MAP_BIT] && !port_wr_hit && !cpu_wr_hit)
        |=> transfer_type_o == dbgcs_pkg::TT_EMULATOR)
        else $error("emulator space not mapped");

    c_port_read:  cover property (@(posedge clk_i) port_rvalid_o);
    c_dbg_int:    cover property (@(posedge clk_i) dbg_int_o);
    c_capture:    cover property (@(posedge clk_i) capture ##1 ser_busy [*3]);
    c_read_clear: cover property (@(posedge clk_i) bs_clear_rd);
endmodule // dbgcs_core

// file: dbgcs_port_model.sv
`timescale 1ns/1ps
// ****************************************
// Debug port host model
// ****************************************
module dbgcs_port_model (
    // Clock
    input  wire logic   clk_i,
    // Port commands
    output logic        port_wr_o,
    output logic        port_rd_o,
    output logic [4:0]  port_idx_o,
    output logic [31:0] port_wdata_o
);
    initial begin
        port_wr_o    = 1'b0;
        port_rd_o    = 1'b0;
        port_idx_o   = 5'h1F;
        port_wdata_o = 32'hFFFF_FFFF;
    end

    // Gap cycles model a slow host
    task automatic write_reg(input logic [4:0] idx, input logic [31:0] d, input int gap);
        repeat (gap + 1) @(negedge clk_i);
        port_idx_o   = idx;
        port_wdata_o = d & 32'hFFFF_FF7F;
        port_wr_o    = 1'b1;
        @(negedge clk_i);
        port_wr_o    = 1'b0;
        port_idx_o   = ~idx;
        port_wdata_o = ~port_wdata_o;
    endtask

    task automatic read_reg(input logic [4:0] idx, input int gap);
        repeat (gap + 1) @(negedge clk_i);
        port_idx_o = idx;
        port_rd_o  = 1'b1;
        @(negedge clk_i);
        port_rd_o  = 1'b0;
        port_idx_o = ~idx;
    endtask
endmodule // dbgcs_port_model

// file: test_dbgcs_core.sv
`timescale 1ns/1ps
// ****************************************
// Testbench
// ****************************************
module test_dbgcs_core;
    localparam logic [3:0]  REV  = 4'hA; // Arbitrary value
    localparam logic [31:0] REVW = {8'h00, REV, 20'h00000};
    localparam logic [31:0] CM   = dbgcs_pkg::CTRL_MASK;
    logic        clk_i = 1'b0, nrst_i = 1'b0;
    logic        cpu_wr_i = 1'b0, cpu_supv_i = 1'b0;
    logic [4:0]  cpu_idx_i = 5'h00;
    logic [31:0] cpu_wdata_i = 32'h0000_0000, op_data_i = 32'h0000_0000;
    logic        port_wr_i, port_rd_i, port_rvalid_o, dbg_int_o, bdm_enter_o;
    logic [4:0]  port_idx_i;
    logic [31:0] port_wdata_i, port_rdata_o;
    logic        tdr_write_i = 1'b0, bp_state_upd_i = 1'b0, level2_enabled_i = 1'b0;
    logic [3:0]  bp_state_i = 4'h0, pst_i = 4'h0;
    logic        double_fault_i = 1'b0, hw_trigger_i = 1'b0, halt_exec_i = 1'b0;
    logic        break_request_input_i = 1'b0, resume_i = 1'b0, sample_point_i = 1'b0;
    logic        dbg_int_done_i = 1'b0, emu_active_i = 1'b0, emu_code_i = 1'b0;
    logic        op_valid_i = 1'b0, op_write_i = 1'b0, trace_exc_i = 1'b0;
    logic [1:0]  op_size_i = 2'h0, transfer_type_o, branch_target_bytes_o;
    logic [2:0]  transfer_modifier_o;
    logic        emu_enter_o, user_halt_permit_o, trace_clock_o;
    logic [3:0]  processor_status_out_o, debug_data_out_o;
    logic [31:0] exp_q[$];
    logic [31:0] w;
    int          fail_count = 0, n_checks = 0, n_int = 0, cyc = 0, seed = 49944;

    dbgcs_core #(.REVISION(REV)) DUT (.clk_i(clk_i), .nrst_i(nrst_i),
        .cpu_wr_i(cpu_wr_i), .cpu_idx_i(cpu_idx_i), .cpu_wdata_i(cpu_wdata_i),
        .cpu_supv_i(cpu_supv_i), .port_wr_i(port_wr_i), .port_rd_i(port_rd_i),
        .port_idx_i(port_idx_i), .port_wdata_i(port_wdata_i), .port_rdata_o(port_rdata_o),
        .port_rvalid_o(port_rvalid_o), .tdr_write_i(tdr_write_i), .bp_state_i(bp_state_i),
        .bp_state_upd_i(bp_state_upd_i), .level2_enabled_i(level2_enabled_i),
        .double_fault_i(double_fault_i), .hw_trigger_i(hw_trigger_i),
        .halt_exec_i(halt_exec_i), .break_request_input_i(break_request_input_i),
        .resume_i(resume_i), .sample_point_i(sample_point_i),
        .dbg_int_done_i(dbg_int_done_i), .dbg_int_o(dbg_int_o), .bdm_enter_o(bdm_enter_o),
        .trace_exc_i(trace_exc_i), .emu_active_i(emu_active_i), .emu_code_i(emu_code_i),
        .emu_enter_o(emu_enter_o), .transfer_type_o(transfer_type_o),
        .transfer_modifier_o(transfer_modifier_o), .user_halt_permit_o(user_halt_permit_o),
        .branch_target_bytes_o(branch_target_bytes_o), .op_valid_i(op_valid_i),
        .op_write_i(op_write_i), .op_size_i(op_size_i), .op_data_i(op_data_i),
        .pst_i(pst_i), .trace_clock_o(trace_clock_o),
        .processor_status_out_o(processor_status_out_o),
        .debug_data_out_o(debug_data_out_o));

    dbgcs_port_model m (.clk_i(clk_i), .port_wr_o(port_wr_i), .port_rd_o(port_rd_i),
        .port_idx_o(port_idx_i), .port_wdata_o(port_wdata_i));

    always #5 clk_i = ~clk_i;

    task automatic give_verdict;
        if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string s);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, s, g, e);
        end
    endtask

    task automatic tk(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic rd(input logic [31:0] e);
        exp_q.push_back(e);
        m.read_reg(5'h00, 0);
        tk(2);
    endtask

    task automatic cpu_wr(input logic [4:0] i, input logic [31:0] d, input logic s);
        cpu_idx_i   = i;
        cpu_wdata_i = d;
        cpu_supv_i  = s;
        cpu_wr_i    = 1'b1;
        tk(1);
        cpu_wr_i    = 1'b0;
        tk(1);
    endtask

    task automatic bp_load(input logic [3:0] v);
        bp_state_i     = v;
        bp_state_upd_i = 1'b1;
        tk(1);
        bp_state_upd_i = 1'b0;
    endtask

    // Read answers checked in order of request
    always @(negedge clk_i) begin
        if (port_rvalid_o === 1'b1) begin
            if (exp_q.size() == 0) cmp(1'b1, 1'b0, "unexpected read answer");
            else cmp(port_rdata_o, exp_q.pop_front(), "read data");
        end
        if (dbg_int_o === 1'b1) n_int++;
        pst_i <= $random(seed);
    end

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 4000) begin
            fail_count++;
            give_verdict();
        end
    end

    initial begin
        tk(3);
        nrst_i = 1'b1;
        rd(REVW);
        m.write_reg(5'h00, 32'hFFFF_FFFF, 1);
        rd(REVW | CM);
        for (int i = 0; i < 4; i++) cmp({trace_clock_o, processor_status_out_o}, 5'h00, "quiet");
        cmp(emu_enter_o, 1'b1, "force emulator");
        cpu_wr(5'h00, 32'h0000_0000, 1'b1);
        rd(REVW | CM);
        m.write_reg(5'h00, 32'h0000_0000, 0);
        cpu_wr(5'h00, 32'h0001_2300, 1'b1);
        cpu_wr(5'h00, 32'h0000_4000, 1'b0);
        cpu_wr(5'h01, 32'h0000_8000, 1'b1);
        m.read_reg(5'h03, 0);
        rd(REVW | 32'h0000_2300);
        for (int i = 0; i < 4; i++) begin
            w = $random(seed);
            m.write_reg(5'h00, w, i);
            rd(REVW | (w & CM));
            cmp({user_halt_permit_o, branch_target_bytes_o}, w[10:8], "fields");
        end
        m.write_reg(5'h00, 32'h0000_0000, 0);
        {double_fault_i, hw_trigger_i, halt_exec_i, break_request_input_i} = 4'hF;
        tk(1);
        cmp(bdm_enter_o, 1'b1, "debug mode entry");
        {double_fault_i, hw_trigger_i, halt_exec_i, break_request_input_i} = 4'h0;
        rd(REVW | 32'h0F00_0000);
        resume_i = 1'b1;
        tk(1);
        resume_i = 1'b0;
        rd(REVW);
        bp_load(4'h6);
        rd(REVW | 32'h6000_0000);
        rd(REVW);
        level2_enabled_i = 1'b1;
        bp_load(4'h2);
        rd(REVW | 32'h2000_0000);
        rd(REVW | 32'h2000_0000);
        tdr_write_i = 1'b1;
        tk(1);
        tdr_write_i = 1'b0;
        rd(REVW);
        level2_enabled_i = 1'b0;
        bp_load(4'h2);
        rd(REVW | 32'h2000_0000);
        bp_load(4'h5);
        rd(REVW | 32'h5000_0000);
        rd(REVW | 32'h5000_0000);
        tdr_write_i = 1'b1;
        tk(1);
        tdr_write_i = 1'b0;
        m.write_reg(5'h00, 32'h0004_0000, 0);
        for (int i = 0; i < 2; i++) begin
            break_request_input_i = 1'b1;
            tk(1);
            break_request_input_i = 1'b0;
            tk(1);
            sample_point_i = 1'b1;
            tk(1);
            sample_point_i = 1'b0;
            tk(3);
            cmp(n_int, 1, "debug interrupt count");
        end
        rd(REVW | 32'h0004_0000);
        dbg_int_done_i = 1'b1;
        m.write_reg(5'h00, 32'h0000_8800, 0);
        dbg_int_done_i = 1'b0;
        {emu_active_i, emu_code_i} = 2'h3;
        tk(1);
        cmp({transfer_type_o, transfer_modifier_o}, 5'h16, "emulator code space");
        emu_code_i = 1'b0;
        tk(1);
        cmp({transfer_type_o, transfer_modifier_o}, 5'h15, "emulator data space");
        for (int k = 0; k < 2; k++) begin
            w = $random(seed);
            op_data_i = {24'h000000, w[7:4] | 4'h1, w[3:0] | 4'h1};
            {op_write_i, op_size_i, op_valid_i} = {~k[0], dbgcs_pkg::SIZE_BYTE, 1'b1};
            tk(1);
            op_valid_i = 1'b0;
            tk(1);
            cmp(debug_data_out_o, k ? 4'h0 : op_data_i[3:0], "low nibble");
            tk(1);
            cmp(debug_data_out_o, k ? 4'h0 : op_data_i[7:4], "high nibble");
            tk(3);
        end
        m.write_reg(5'h00, 32'h0000_4000, 0);
        trace_exc_i = 1'b1;
        tk(1);
        cmp(emu_enter_o, 1'b1, "trace enters emulator");
        trace_exc_i = 1'b0;
        tk(1);
        cmp(emu_enter_o, 1'b0, "no trace no emulator");
        give_verdict();
    end
endmodule // test_dbgcs_core
